// >>> hw/wkt_tick_gen.v
// low clock enable generator and tick prescaler of the wake timer
`timescale 1ns/1ps
`include "wkt_regs.vh"

module wkt_tick_gen #(
  parameter [26:0] LOW_STEP = `WKT_LOW_HZ
) (
  input  wire        clock,
  input  wire        rst_b,
  input  wire        osc_on,
  input  wire        restart,
  input  wire [2:0]  div_sel,
  output reg         tick_r
);

  // ----------------------------------------------------------------
  // divider table, held as terminal count (divider minus one)
  // ----------------------------------------------------------------
  function [15:0] div_last;
    input [2:0] sel;
    begin
      case (sel)
        3'd0:    div_last = `WKT_DIV_LAST_0;
        3'd1:    div_last = `WKT_DIV_LAST_1;
        3'd2:    div_last = `WKT_DIV_LAST_2;
        3'd3:    div_last = `WKT_DIV_LAST_3;
        3'd4:    div_last = `WKT_DIV_LAST_4;
        3'd5:    div_last = `WKT_DIV_LAST_5;
        3'd6:    div_last = `WKT_DIV_LAST_6;
        default: div_last = `WKT_DIV_LAST_7;
      endcase
    end
  endfunction

  reg  [26:0] acc_r;
  reg  [15:0] pre_r;
  wire [27:0] acc_sum = {1'b0, acc_r} + {1'b0, LOW_STEP};
  // fractional accumulator: 100 MHz is no whole multiple of 32.768 kHz
  wire        low_en  = osc_on && (acc_sum >= {1'b0, `WKT_CLK_HZ});

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      acc_r  <= 27'd0;
      pre_r  <= 16'h0000;
      tick_r <= 1'b0;
    end else begin
      tick_r <= 1'b0;
      if (restart) begin
        acc_r <= 27'd0;
        pre_r <= 16'h0000;
      end else if (osc_on) begin
        if (low_en)
          acc_r <= acc_sum[26:0] - `WKT_CLK_HZ;
        else
          acc_r <= acc_sum[26:0];
        if (low_en) begin
          if (pre_r >= div_last(div_sel)) begin
            pre_r  <= 16'h0000;
            tick_r <= 1'b1;
          end else begin
            pre_r <= pre_r + 16'h0001;
          end
        end
      end
    end
  end

endmodule

// >>> hw/wkt_top.v
// wake timer with wake counter, AXI4-Lite register slave
//
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "wkt_regs.vh"

module wkt_top #(
  parameter [26:0] LOW_STEP = `WKT_LOW_HZ
) (
  input  wire        clock,
  input  wire        rst_b,
  input  wire [11:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [11:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output reg         host_interrupt_pin,
  output reg         rc_osc_enable,
  output reg         crystal_osc_enable,
  output reg         low_clock_source_select,
  output reg  [3:0]  rc_coarse_trim,
  output reg         retention_ram_power,
  output reg         sleep_state,
  output reg         off_state,
  output reg         wake_pulse
);

  // ----------------------------------------------------------------
  // power states
  // ----------------------------------------------------------------
  localparam [1:0] ST_ON    = 2'd0;
  localparam [1:0] ST_SLEEP = 2'd1;
  localparam [1:0] ST_OFF   = 2'd2;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function [11:0] byte_addr;
    input [11:0] idx;
    begin
      byte_addr = {idx[9:0], 2'b00};
    end
  endfunction

  function [7:0] lane_merge;
    input [7:0] old_v;
    input [7:0] new_v;
    input       en;
    begin
      lane_merge = en ? new_v : old_v;
    end
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  reg  [11:0] wr_addr_r;
  reg  [31:0] wr_data_r;
  reg  [3:0]  wr_strb_r;
  reg  [7:0]  irq_mask_r;
  reg  [7:0]  irq_status_r;
  reg  [15:0] wake_count_r;
  reg  [15:0] threshold_r;
  reg  [7:0]  cfg_upper_shadow_r;
  reg  [7:0]  cfg_upper_r;
  reg  [7:0]  cfg_lower_r;
  reg  [7:0]  val_upper_shadow_r;
  reg         cfg_pair_open_r;
  reg         val_pair_open_r;
  reg  [15:0] wake_timer_reload_r;
  reg  [15:0] down_count_r;
  reg         timer_run_r;
  reg  [1:0]  state_r;
  reg  [1:0]  state_nxt;
  reg  [7:0]  irq_set;
  reg  [15:0] wake_count_nxt;
  reg  [31:0] rd_data;
  reg  [1:0]  rd_resp;
  reg  [1:0]  wr_resp;
  wire        tick;
  wire        timer_load;
  wire        timeout;
  wire        osc_on;
  wire [16:0] count_plus;
  wire        wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  wire        wr_lane0 = wr_go && wr_strb_r[0];
  wire [7:0]  wr_byte0 = wr_data_r[7:0];

  // ----------------------------------------------------------------
  // tick source: selected oscillator must also be enabled
  // ----------------------------------------------------------------
  assign osc_on = cfg_lower_r[`WKT_CFGL_CLKSEL] ?
                  cfg_lower_r[`WKT_CFGL_RCOSC_EN] :
                  cfg_lower_r[`WKT_CFGL_XOSC_EN];

  assign timer_load = wr_lane0 && val_pair_open_r &&
                      (wr_addr_r == byte_addr(`WKT_IDX_VAL_LOWER));

  wkt_tick_gen #(
    .LOW_STEP (LOW_STEP)
  ) u_tick (
    .clock   (clock),
    .rst_b   (rst_b),
    .osc_on  (osc_on && timer_run_r),
    .restart (timer_load),
    .div_sel (cfg_upper_r[`WKT_CFGH_DIV_MSB:`WKT_CFGH_DIV_LSB]),
    .tick_r  (tick)
  );

  // reaching zero on this tick; a zero value never expires
  assign timeout    = timer_run_r && tick && (down_count_r == 16'h0001);
  assign count_plus = {1'b0, wake_count_r} + 17'd1;

  // ----------------------------------------------------------------
  // write address / data channels, taken in either order
  // ----------------------------------------------------------------
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `WKT_RESP_OKAY;
      wr_addr_r     <= 12'h000;
      wr_data_r     <= `WKT_RST_WORD;
      wr_strb_r     <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        wr_addr_r     <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wr_data_r    <= s_axi_wdata;
        wr_strb_r    <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_resp;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always @* begin
    if (wr_addr_r == byte_addr(`WKT_IDX_IRQ_MASK) ||
        wr_addr_r == byte_addr(`WKT_IDX_WAKE_COUNT) ||
        wr_addr_r == byte_addr(`WKT_IDX_THRESHOLD) ||
        wr_addr_r == byte_addr(`WKT_IDX_CFG_UPPER) ||
        wr_addr_r == byte_addr(`WKT_IDX_CFG_LOWER) ||
        wr_addr_r == byte_addr(`WKT_IDX_VAL_UPPER) ||
        wr_addr_r == byte_addr(`WKT_IDX_VAL_LOWER) ||
        wr_addr_r == byte_addr(`WKT_IDX_IRQ_STATUS) ||
        wr_addr_r == byte_addr(`WKT_IDX_POWER_CTRL))
      wr_resp = `WKT_RESP_OKAY;
    else
      wr_resp = `WKT_RESP_SLVERR;
  end

  // ----------------------------------------------------------------
  // read channel, answer one cycle after the address is taken
  // ----------------------------------------------------------------
  always @* begin
    rd_data = `WKT_RST_WORD;
    rd_resp = `WKT_RESP_OKAY;
    if (s_axi_araddr == byte_addr(`WKT_IDX_IRQ_MASK)) begin
      rd_data[7:0] = irq_mask_r;
    end else if (s_axi_araddr == byte_addr(`WKT_IDX_WAKE_COUNT)) begin
      rd_data[15:0] = wake_count_r;
    end else if (s_axi_araddr == byte_addr(`WKT_IDX_THRESHOLD)) begin
      rd_data[15:0] = threshold_r;
    end else if (s_axi_araddr == byte_addr(`WKT_IDX_IRQ_STATUS)) begin
      rd_data[7:0] = irq_status_r;
    end else if (s_axi_araddr == byte_addr(`WKT_IDX_POWER_CTRL)) begin
      rd_data[1:0] = state_r;
    end else if (s_axi_araddr == byte_addr(`WKT_IDX_CFG_UPPER) ||
                 s_axi_araddr == byte_addr(`WKT_IDX_CFG_LOWER) ||
                 s_axi_araddr == byte_addr(`WKT_IDX_VAL_UPPER) ||
                 s_axi_araddr == byte_addr(`WKT_IDX_VAL_LOWER)) begin
      rd_data = `WKT_RST_WORD;
    end else begin
      rd_resp = `WKT_RESP_SLVERR;
    end
  end

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= `WKT_RST_WORD;
      s_axi_rresp   <= `WKT_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_data;
      s_axi_rresp   <= rd_resp;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // power state and wake counter
  // ----------------------------------------------------------------
  always @* begin
    state_nxt      = state_r;
    wake_count_nxt = wake_count_r;
    irq_set        = 8'h00;
    if (timeout)
      irq_set[`WKT_IRQ_TIMEOUT] = 1'b1;
    case (state_r)
      ST_SLEEP: begin
        if (timeout && cfg_lower_r[`WKT_CFGL_ARM]) begin
          wake_count_nxt = count_plus[15:0];
          if (count_plus > {1'b0, threshold_r}) begin
            wake_count_nxt = `WKT_RST_HALF;
            irq_set[`WKT_IRQ_WAKE_COUNT] = 1'b1;
            if (irq_mask_r[`WKT_IRQ_WAKE_COUNT])
              state_nxt = ST_OFF;
          end
        end
      end
      ST_ON, ST_OFF: begin
        if (wr_lane0 && wr_byte0[`WKT_PWR_SLEEP] &&
            wr_addr_r == byte_addr(`WKT_IDX_POWER_CTRL))
          state_nxt = ST_SLEEP;
      end
      default: state_nxt = ST_ON;
    endcase
    if (wr_lane0 && wr_byte0[`WKT_PWR_WAKE] &&
        wr_addr_r == byte_addr(`WKT_IDX_POWER_CTRL))
      state_nxt = ST_ON;
  end

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_r      <= ST_ON;
      wake_count_r <= `WKT_RST_HALF;
      irq_status_r <= `WKT_RST_BYTE;
      wake_pulse   <= 1'b0;
    end else begin
      state_r      <= state_nxt;
      wake_count_r <= wake_count_nxt;
      // a new event wins over a clear in the same cycle
      if (wr_lane0 && wr_addr_r == byte_addr(`WKT_IDX_IRQ_STATUS))
        irq_status_r <= (irq_status_r & ~wr_byte0) | irq_set;
      else
        irq_status_r <= irq_status_r | irq_set;
      wake_pulse <= (state_r == ST_SLEEP) && timeout &&
                    cfg_lower_r[`WKT_CFGL_ARM];
    end
  end

  // ----------------------------------------------------------------
  // software registers and byte pairs
  // ----------------------------------------------------------------
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      irq_mask_r          <= `WKT_RST_BYTE;
      threshold_r         <= `WKT_RST_HALF;
      cfg_upper_shadow_r  <= `WKT_RST_BYTE;
      cfg_upper_r         <= `WKT_RST_BYTE;
      cfg_lower_r         <= `WKT_RST_BYTE;
      val_upper_shadow_r  <= `WKT_RST_BYTE;
      cfg_pair_open_r     <= 1'b0;
      val_pair_open_r     <= 1'b0;
      wake_timer_reload_r <= `WKT_RST_HALF;
    end else if (wr_go) begin
      // a lower byte only counts right after its upper byte
      cfg_pair_open_r <= 1'b0;
      val_pair_open_r <= 1'b0;
      if (wr_addr_r == byte_addr(`WKT_IDX_IRQ_MASK)) begin
        irq_mask_r <= lane_merge(irq_mask_r, wr_byte0, wr_strb_r[0]);
      end else if (wr_addr_r == byte_addr(`WKT_IDX_THRESHOLD)) begin
        threshold_r[7:0]  <= lane_merge(threshold_r[7:0], wr_byte0,
                                        wr_strb_r[0]);
        threshold_r[15:8] <= lane_merge(threshold_r[15:8],
                                        wr_data_r[15:8], wr_strb_r[1]);
      end else if (wr_addr_r == byte_addr(`WKT_IDX_CFG_UPPER)) begin
        if (wr_strb_r[0]) begin
          cfg_upper_shadow_r <= wr_byte0;
          cfg_pair_open_r    <= 1'b1;
        end
      end else if (wr_addr_r == byte_addr(`WKT_IDX_CFG_LOWER)) begin
        if (wr_strb_r[0] && cfg_pair_open_r) begin
          cfg_upper_r <= cfg_upper_shadow_r;
          cfg_lower_r <= wr_byte0;
        end
      end else if (wr_addr_r == byte_addr(`WKT_IDX_VAL_UPPER)) begin
        if (wr_strb_r[0]) begin
          val_upper_shadow_r <= wr_byte0;
          val_pair_open_r    <= 1'b1;
        end
      end else if (timer_load) begin
        wake_timer_reload_r <= {val_upper_shadow_r, wr_byte0};
      end
    end
  end

  // ----------------------------------------------------------------
  // wake timer down counter
  // ----------------------------------------------------------------
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      down_count_r <= `WKT_RST_HALF;
      timer_run_r  <= 1'b0;
    end else if (timer_load) begin
      down_count_r <= {val_upper_shadow_r, wr_byte0};
      timer_run_r  <= ({val_upper_shadow_r, wr_byte0} != `WKT_RST_HALF);
    end else if (timeout) begin
      down_count_r <= wake_timer_reload_r;
    end else if (timer_run_r && tick) begin
      down_count_r <= down_count_r - 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      host_interrupt_pin      <= 1'b0;
      rc_osc_enable           <= 1'b0;
      crystal_osc_enable      <= 1'b0;
      low_clock_source_select <= 1'b0;
      rc_coarse_trim          <= 4'h0;
      retention_ram_power     <= 1'b1;
      sleep_state             <= 1'b0;
      off_state               <= 1'b0;
    end else begin
      host_interrupt_pin      <= |(irq_status_r & irq_mask_r);
      rc_osc_enable           <= cfg_lower_r[`WKT_CFGL_RCOSC_EN];
      crystal_osc_enable      <= cfg_lower_r[`WKT_CFGL_XOSC_EN];
      low_clock_source_select <= cfg_lower_r[`WKT_CFGL_CLKSEL];
      rc_coarse_trim          <=
        cfg_upper_r[`WKT_CFGH_TRIM_MSB:`WKT_CFGH_TRIM_LSB];
      // retention RAM loses power only while asleep with retain off
      retention_ram_power     <= (state_r != ST_SLEEP) ||
                                 cfg_lower_r[`WKT_CFGL_RETAIN];
      sleep_state             <= (state_r == ST_SLEEP);
      off_state               <= (state_r == ST_OFF);
    end
  end

endmodule

// >>> include/wkt_regs.vh
// register map, field positions and timing constants of the wake timer
`ifndef WKT_REGS_VH
`define WKT_REGS_VH

// ----------------------------------------------------------------
// register indexes (byte address is four times the index)
// ----------------------------------------------------------------
`define WKT_IDX_IRQ_MASK    12'h100
`define WKT_IDX_WAKE_COUNT  12'h103
`define WKT_IDX_THRESHOLD   12'h104
`define WKT_IDX_CFG_UPPER   12'h30C
`define WKT_IDX_CFG_LOWER   12'h30D
`define WKT_IDX_VAL_UPPER   12'h30E
`define WKT_IDX_VAL_LOWER   12'h30F
`define WKT_IDX_IRQ_STATUS  12'h120
`define WKT_IDX_POWER_CTRL  12'h121

// ----------------------------------------------------------------
// lower configuration byte fields
// ----------------------------------------------------------------
`define WKT_CFGL_ARM        0
`define WKT_CFGL_RETAIN     3
`define WKT_CFGL_CLKSEL     4
`define WKT_CFGL_XOSC_EN    5
`define WKT_CFGL_RCOSC_EN   6

// ----------------------------------------------------------------
// upper configuration byte fields
// ----------------------------------------------------------------
`define WKT_CFGH_DIV_MSB    2
`define WKT_CFGH_DIV_LSB    0
`define WKT_CFGH_TRIM_MSB   6
`define WKT_CFGH_TRIM_LSB   3

// ----------------------------------------------------------------
// prescaler terminal counts (divider minus one)
// ----------------------------------------------------------------
`define WKT_DIV_LAST_0      16'h0000
`define WKT_DIV_LAST_1      16'h0003
`define WKT_DIV_LAST_2      16'h0007
`define WKT_DIV_LAST_3      16'h000F
`define WKT_DIV_LAST_4      16'h007F
`define WKT_DIV_LAST_5      16'h03FF
`define WKT_DIV_LAST_6      16'h1FFF
`define WKT_DIV_LAST_7      16'hFFFF

// ----------------------------------------------------------------
// interrupt status / mask bits, power control bits
// ----------------------------------------------------------------
`define WKT_IRQ_TIMEOUT     0
`define WKT_IRQ_WAKE_COUNT  1
`define WKT_PWR_SLEEP       0
`define WKT_PWR_WAKE        1

// ----------------------------------------------------------------
// reset values and bus answers
// ----------------------------------------------------------------
`define WKT_RST_BYTE        8'h00
`define WKT_RST_HALF        16'h0000
`define WKT_RST_WORD        32'h0000_0000
`define WKT_RESP_OKAY       2'b00
`define WKT_RESP_SLVERR     2'b10

// ----------------------------------------------------------------
// timing: system clock and low clock rate in hertz
// ----------------------------------------------------------------
`define WKT_CLK_HZ          27'd100000000
`define WKT_LOW_HZ          27'd32768

`endif

// >>> tb/tb.sv
// self-checking bench of the wake timer
`timescale 1ns/1ps
`include "wkt_regs.vh"
module tb;
  reg         clock = 1'b0;
  reg         rst_b = 1'b0;
  integer     fails = 0;
  integer     n_tests = 0;
  integer     i, t;
  int         dv [6] = '{1, 4, 8, 16, 128, 1024};
  reg  [11:0] a;
  reg  [31:0] d;
  reg  [1:0]  r;
  wire [11:0] s_axi_awaddr, s_axi_araddr;
  wire [31:0] s_axi_wdata, s_axi_rdata;
  wire [3:0]  s_axi_wstrb, rc_coarse_trim;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  wire s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  wire s_axi_rvalid, s_axi_rready, host_interrupt_pin, rc_osc_enable;
  wire crystal_osc_enable, low_clock_source_select, retention_ram_power;
  wire sleep_state, off_state, wake_pulse;
  // low clock every 4 cycles keeps the run short
  wkt_top #(.LOW_STEP(27'h17D_7840)) wkt_top_i (
    .clock, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .host_interrupt_pin, .rc_osc_enable, .crystal_osc_enable,
    .low_clock_source_select, .rc_coarse_trim, .retention_ram_power,
    .sleep_state, .off_state, .wake_pulse
  );
  wkt_host_model wkt_host_model_i (
    .clock, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );
  initial forever #5 clock = ~clock;
  task test_done;
    begin
      $display("tests %0d fails %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask
  task chk(input [31:0] g, input [31:0] e);
    begin
      n_tests = n_tests + 1;
      if (g !== e) begin
        fails = fails + 1;
        $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
    end
  endtask
  task w(input [11:0] wa, input [31:0] v);
    begin
      wkt_host_model_i.wr(wa, v, r);
      chk({30'h0, r}, {30'h0, `WKT_RESP_OKAY});
    end
  endtask
  task rchk(input [11:0] ra, input [31:0] e, input [1:0] er);
    begin
      wkt_host_model_i.rd(ra, d, r);
      chk(d, e);
      chk({30'h0, r}, {30'h0, er});
    end
  endtask
  task setup(input [7:0] hi, input [7:0] lo, input [15:0] v);
    begin
      w(12'hC30, {24'h0, hi});
      w(12'hC34, {24'h0, lo});
      w(12'hC38, {24'h0, v[15:8]});
      w(12'hC3C, {24'h0, v[7:0]});
      repeat (2) @(posedge clock);
    end
  endtask
  task pulse;
    begin
      t = 0;
      do begin
        @(posedge clock);
        t = t + 1;
      end while (!wake_pulse);
    end
  endtask
  initial begin
    repeat (80000) @(posedge clock);
    fails = fails + 1;
    test_done;
  end
  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clock);
    rst_b <= 1'b1;
    rchk(12'h40C, 32'h0, `WKT_RESP_OKAY);
    setup(8'h28, 8'h79, 16'h0002);
    chk({25'h0, rc_osc_enable, crystal_osc_enable,
         low_clock_source_select, rc_coarse_trim}, 32'h75);
    for (a = 12'hC30; a < 12'hC40; a = a + 12'h004)
      rchk(a, 32'h0, `WKT_RESP_OKAY);
    wkt_host_model_i.wr(12'hFFC, 32'h1, r);
    chk({30'h0, r}, {30'h0, `WKT_RESP_SLVERR});
    rchk(12'hFFC, 32'h0, `WKT_RESP_SLVERR);
    setup(8'h00, 8'h21, 16'h0002);
    chk({29'h0, rc_osc_enable, crystal_osc_enable,
         low_clock_source_select}, 32'h2);
    w(12'h410, 32'h2);
    w(12'h400, 32'h2);
    rchk(12'h400, 32'h2, `WKT_RESP_OKAY);
    setup(8'h00, 8'h79, 16'h0002);
    w(12'h480, 32'h3);
    w(12'h484, 32'h1);
    chk({30'h0, sleep_state, retention_ram_power}, 32'h3);
    for (i = 1; i < 3; i = i + 1) begin
      pulse;
      rchk(12'h40C, i, `WKT_RESP_OKAY);
    end
    pulse;
    repeat (3) @(posedge clock);
    chk({29'h0, off_state, sleep_state, host_interrupt_pin}, 32'h5);
    rchk(12'h40C, 32'h0, `WKT_RESP_OKAY);
    rchk(12'h480, 32'h3, `WKT_RESP_OKAY);
    w(12'h480, 32'h3);
    repeat (2) @(posedge clock);
    chk({31'h0, host_interrupt_pin}, 32'h0);
    w(12'h484, 32'h2);
    setup(8'h00, 8'h70, 16'h0002);
    w(12'h484, 32'h1);
    t = 0;
    repeat (200) begin
      @(posedge clock);
      if (wake_pulse) t = t + 1;
    end
    chk(t, 0);
    chk({30'h0, sleep_state, retention_ram_power}, 32'h2);
    rchk(12'h40C, 32'h0, `WKT_RESP_OKAY);
    w(12'h410, 32'h0000_FFFF);
    for (i = 0; i < 6; i = i + 1) begin
      setup(i[7:0], 8'h51, 16'h0002);
      pulse;
      pulse;
      chk(t, 8 * dv[i]);
    end
    // code 6 timed once: load lands four edges before setup returns
    setup(8'h06, 8'h51, 16'h0001);
    pulse;
    chk(t, 4 * 8192 - 2);
    chk({31'h0, host_interrupt_pin}, 32'h0);
    w(12'h400, 32'h3);
    repeat (3) @(posedge clock);
    chk({31'h0, host_interrupt_pin}, 32'h1);
    test_done;
  end
endmodule

// >>> tb/wkt_host_model.sv
// axi4-lite host that programs the wake timer
`timescale 1ns/1ps
module wkt_host_model (
  input  wire        clock,
  output reg  [11:0] s_axi_awaddr,
  output reg         s_axi_awvalid,
  input  wire        s_axi_awready,
  output reg  [31:0] s_axi_wdata,
  output reg  [3:0]  s_axi_wstrb,
  output reg         s_axi_wvalid,
  input  wire        s_axi_wready,
  input  wire [1:0]  s_axi_bresp,
  input  wire        s_axi_bvalid,
  output reg         s_axi_bready,
  output reg  [11:0] s_axi_araddr,
  output reg         s_axi_arvalid,
  input  wire        s_axi_arready,
  input  wire [31:0] s_axi_rdata,
  input  wire [1:0]  s_axi_rresp,
  input  wire        s_axi_rvalid,
  output reg         s_axi_rready
);
  initial begin
    {s_axi_awaddr, s_axi_araddr} = 24'h00_0000;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hF;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
  end
  // ready raised a cycle late so the slave must hold its answer
  task automatic wr(input [11:0] a, input [31:0] v, output [1:0] r);
    begin
      @(posedge clock);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do begin
        @(posedge clock);
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
        s_axi_bready <= s_axi_bvalid && !s_axi_bready;
      end while (!(s_axi_bvalid && s_axi_bready));
      r = s_axi_bresp;
    end
  endtask
  task automatic rd(input [11:0] a, output [31:0] d, output [1:0] r);
    begin
      @(posedge clock);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do begin
        @(posedge clock);
        if (s_axi_arready) s_axi_arvalid <= 1'b0;
        s_axi_rready <= s_axi_rvalid && !s_axi_rready;
      end while (!(s_axi_rvalid && s_axi_rready));
      d = s_axi_rdata;
      r = s_axi_rresp;
    end
  endtask
endmodule

// >>> tb/wkt_top_assertions.sv
// port assertions of the wake timer
`timescale 1ns/1ps
module wkt_top_assertions (
  input wire        clock,
  input wire        rst_b,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire        host_interrupt_pin,
  input wire        retention_ram_power,
  input wire        sleep_state,
  input wire        off_state,
  input wire        wake_pulse
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_b_wait;
    s_axi_bvalid && !s_axi_bready;
  endsequence
  property p_b_lat;
    s_wr_take |-> ##2 s_axi_bvalid;
  endproperty
  property p_b_hold;
    s_b_wait |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  property p_wr_block;
    s_wr_take |=> !s_axi_awready && !s_axi_wready;
  endproperty
  property p_r_lat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  property p_off_irq;
    $rose(off_state) |-> ##[1:3] host_interrupt_pin;
  endproperty
  property p_wake;
    wake_pulse |-> (sleep_state || off_state) ##1 !wake_pulse;
  endproperty
  property p_ret;
    (!sleep_state) [*2] |-> retention_ram_power;
  endproperty
  property p_one_state;
    !(sleep_state && off_state);
  endproperty
  a_b_lat: assert property (p_b_lat) else $error("write answer late");
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  a_wr_block: assert property (p_wr_block) else $error("write not blocked");
  a_r_lat: assert property (p_r_lat) else $error("read answer late");
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
  a_off_irq: assert property (p_off_irq) else $error("no irq at off");
  a_wake: assert property (p_wake) else $error("bad wake pulse");
  a_ret: assert property (p_ret) else $error("ram power lost");
  a_one_state: assert property (p_one_state) else $error("two states");
endmodule

bind wkt_top wkt_top_assertions wkt_top_assertions_i (
  .clock, .rst_b, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .host_interrupt_pin, .retention_ram_power,
  .sleep_state, .off_state, .wake_pulse
);
